// [src/mcrb_pkg.sv]
// Constants and field layouts for the monitor control register bank.
// Assumes a serial master that frames each access with an active-low chip select.
//
// What this block does
// - Settings reached only through serial register access
// - Direction flag low writes, high reads
// - Eleven registers 00H-0AH, reset 00H, else test
// - Scratch register stores and returns eight bits
// - Cell selector: enable bit4, index bits3-0
// - Disabled cell output held at zero volts
// - Index n routes cell n+1 to output
// - Current register: enable, cal out, cal in, zero, gain
// - Gain bit selects ten or fifty
// - Zero correction grounds both sense inputs
// - Zero correction overrides both calibration bits
// - Cal input grounds negative, references positive
// - Both cal bits present reference on output
// - Current output enable: zero volts or amplifier
// - Short detection ignores current monitor settings
package mcrb_pkg;

  localparam int unsigned NUM_REGS       = 11;
  localparam int unsigned ADDR_W         = 7;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned NUM_CELLS      = 16;
  localparam int unsigned FRAME_BITS     = 16;

  // Register offsets
  localparam logic [6:0] ADDR_SCRATCH    = 7'h00;
  localparam logic [6:0] ADDR_CELL_SEL   = 7'h01;
  localparam logic [6:0] ADDR_CUR_MON    = 7'h02;
  localparam logic [6:0] ADDR_SWITCH_DRV = 7'h03;
  localparam logic [6:0] ADDR_CHG_DET    = 7'h04;
  localparam logic [6:0] ADDR_LOAD_SHORT = 7'h05;
  localparam logic [6:0] ADDR_POWER_MODE = 7'h06;
  localparam logic [6:0] ADDR_INT_STATE  = 7'h07;
  localparam logic [6:0] ADDR_BAL_UPPER  = 7'h08;
  localparam logic [6:0] ADDR_BAL_LOWER  = 7'h09;
  localparam logic [6:0] ADDR_SHORT_THR  = 7'h0A;

  // Reset value of every register, the test register included
  localparam logic [7:0] REG_RESET       = 8'h00;

  // Cell selector fields
  localparam int unsigned CELL_EN_BIT    = 4;
  localparam int unsigned CELL_IDX_MSB   = 3;
  localparam logic [7:0] CELL_SEL_MASK   = 8'h1F;

  // Current monitor fields
  localparam int unsigned CM_OUT_EN_BIT  = 4;
  localparam int unsigned CM_CAL_OUT_BIT = 3;
  localparam int unsigned CM_CAL_IN_BIT  = 2;
  localparam int unsigned CM_ZERO_BIT    = 1;
  localparam int unsigned CM_GAIN_BIT    = 0;
  localparam logic [7:0] CUR_MON_MASK    = 8'h1F;

  // Frame layout: command byte bit 7 is the direction flag
  localparam int unsigned RW_BIT         = 7;
  localparam logic       DIR_WRITE       = 1'b0;
  localparam logic       DIR_READ        = 1'b1;
  localparam logic [3:0] CNT_CMD_DONE    = 4'h8;
  localparam logic [3:0] CNT_LAST_BIT    = 4'hF;

endpackage : mcrb_pkg

// [src/mcrb_sync.sv]
// Two-stage level synchroniser into the system clock domain.
// Assumes the input is a level that holds for several destination cycles.
`timescale 1ns/1ps
module mcrb_sync
  import mcrb_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic async_i,
  output logic      sync_o
);

  typedef struct packed {
    logic meta;
    logic stable;
  } mcrb_sync_state_t;

  mcrb_sync_state_t s_q;
  mcrb_sync_state_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.meta   = async_i;
    s_d.stable = s_q.meta;
    if (!rstn_i) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign sync_o = s_q.stable;

endmodule : mcrb_sync

// [src/mcrb_top.sv]
// Serial slave and control register bank of a battery monitor front end.
// Assumes a mode-0 serial master: data sampled on rising and shifted on falling clock,
// serial clock idle low and stopped outside frames, chip select high between frames.
`timescale 1ns/1ps
module mcrb_top
  import mcrb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic        serial_in_i,
  output logic             serial_out_o,
  output logic             serial_out_oe_o,
  input  wire logic        short_detect_i,
  output logic             short_trip_o,
  output logic [15:0]      cell_tap_sel_o,
  output logic             cell_voltage_output_en_o,
  output logic             amp_gain_select_o,
  output logic             sense_positive_in_gnd_o,
  output logic             sense_negative_in_gnd_o,
  output logic             sense_positive_in_ref_o,
  output logic             ref_level_20mv_o,
  output logic             current_monitor_output_ref_o,
  output logic             current_monitor_output_en_o,
  output logic [7:0]       switch_driver_ctrl_o,
  output logic [7:0]       charger_detect_ctrl_o,
  output logic [7:0]       load_short_detect_ctrl_o,
  output logic [7:0]       power_mode_ctrl_o,
  output logic [7:0]       internal_state_o,
  output logic [7:0]       balance_upper_cells_o,
  output logic [7:0]       balance_lower_cells_o,
  output logic [7:0]       short_threshold_select_o
);

  // Link side, rising edge: frame decode
  typedef struct packed {
    logic [3:0] cnt;
    logic [6:0] shift;
    logic       dir;
    logic [6:0] addr;
  } mcrb_frame_t;

  // Link side, rising edge: write hand-off, survives chip select
  typedef struct packed {
    logic       tgl;
    logic [6:0] addr;
    logic [7:0] data;
  } mcrb_wr_t;

  // Link side, falling edge: read shifter
  typedef struct packed {
    logic [6:0] shift;
    logic       serial_out;
    logic       oe;
  } mcrb_rd_t;

  // System side
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic [7:0]               test;
    logic                     tgl_seen;
    logic                     short_trip;
    logic [15:0]              cell_tap;
    logic                     cell_en;
    logic                     gain;
    logic                     p_gnd;
    logic                     n_gnd;
    logic                     p_ref;
    logic                     ref20;
    logic                     out_ref;
    logic                     out_en;
  } mcrb_sys_t;

  mcrb_frame_t fr_q;
  mcrb_frame_t fr_d;
  mcrb_wr_t    wr_q;
  mcrb_wr_t    wr_d;
  mcrb_rd_t    rd_q;
  mcrb_rd_t    rd_d;
  mcrb_sys_t   sy_q;
  mcrb_sys_t   sy_d;

  logic        wr_tgl_sync;
  logic        short_sync;
  logic [7:0]  rd_word;

  always_comb begin
    fr_d       = fr_q;
    wr_d       = wr_q;
    fr_d.cnt   = fr_q.cnt + 4'h1;
    fr_d.shift = {fr_q.shift[5:0], serial_in_i};
    if (fr_q.cnt == CNT_CMD_DONE - 4'h1) begin
      fr_d.dir  = fr_q.shift[6];
      fr_d.addr = {fr_q.shift[5:0], serial_in_i};
    end
    if (fr_q.cnt == CNT_LAST_BIT && fr_q.dir == DIR_WRITE) begin
      wr_d.tgl  = ~wr_q.tgl;
      wr_d.addr = fr_q.addr;
      wr_d.data = {fr_q.shift, serial_in_i};
    end
  end

  // Frame state restarts on every chip select, so a short frame leaves nothing behind
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fr_q <= '0;
    end else begin
      fr_q <= fr_d;
    end
  end

  // Held between frames because the link clock stops; reset by the system reset
  always_ff @(posedge sck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q <= '0;
    end else begin
      wr_q <= wr_d;
    end
  end

  // read decode, unmapped goes to test
  // Registers change only through this link, so they are quiet during a read frame
  always_comb begin
    rd_word = sy_q.test;
    if (fr_q.addr < 7'(NUM_REGS)) begin
      rd_word = sy_q.regs[fr_q.addr[3:0]];
    end
  end

  // read data shifted out on falling edge
  always_comb begin
    rd_d = rd_q;
    if (fr_q.cnt == CNT_CMD_DONE && fr_q.dir == DIR_READ) begin
      rd_d.serial_out   = rd_word[7];
      rd_d.shift = rd_word[6:0];
      rd_d.oe    = 1'b1;
    end else if (fr_q.cnt > CNT_CMD_DONE && rd_q.oe) begin
      rd_d.serial_out   = rd_q.shift[6];
      rd_d.shift = {rd_q.shift[5:0], 1'b0};
    end
  end

  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign serial_out_o    = rd_q.serial_out;
  assign serial_out_oe_o = rd_q.oe;

  mcrb_sync u_wr_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (wr_q.tgl),
    .sync_o  (wr_tgl_sync)
  );

  mcrb_sync u_short_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (short_detect_i),
    .sync_o  (short_sync)
  );

  always_comb begin
    sy_d          = sy_q;
    sy_d.tgl_seen = wr_tgl_sync;
    if (wr_tgl_sync != sy_q.tgl_seen) begin
      if (wr_q.addr < 7'(NUM_REGS)) begin
        sy_d.regs[wr_q.addr[3:0]] = wr_q.data;
      end else begin
        sy_d.test = wr_q.data;
      end
      sy_d.regs[ADDR_CELL_SEL[3:0]] = sy_d.regs[ADDR_CELL_SEL[3:0]] & CELL_SEL_MASK;
      sy_d.regs[ADDR_CUR_MON[3:0]]  = sy_d.regs[ADDR_CUR_MON[3:0]] & CUR_MON_MASK;
    end

    sy_d.short_trip = short_sync;

    sy_d.cell_en  = sy_q.regs[ADDR_CELL_SEL[3:0]][CELL_EN_BIT];
    sy_d.cell_tap = '0;
    if (sy_d.cell_en) begin
      sy_d.cell_tap[sy_q.regs[ADDR_CELL_SEL[3:0]][CELL_IDX_MSB:0]] = 1'b1;
    end

    sy_d.gain    = sy_q.regs[ADDR_CUR_MON[3:0]][CM_GAIN_BIT];
    sy_d.out_en  = sy_q.regs[ADDR_CUR_MON[3:0]][CM_OUT_EN_BIT];
    sy_d.p_gnd   = 1'b0;
    sy_d.n_gnd   = 1'b0;
    sy_d.p_ref   = 1'b0;
    sy_d.ref20   = 1'b0;
    sy_d.out_ref = 1'b0;
    if (sy_q.regs[ADDR_CUR_MON[3:0]][CM_ZERO_BIT]) begin
      sy_d.p_gnd = 1'b1;
      sy_d.n_gnd = 1'b1;
    end else if (sy_q.regs[ADDR_CUR_MON[3:0]][CM_CAL_IN_BIT]) begin
      sy_d.n_gnd   = 1'b1;
      sy_d.p_ref   = 1'b1;
      sy_d.ref20   = sy_q.regs[ADDR_CUR_MON[3:0]][CM_GAIN_BIT];
      sy_d.out_ref = sy_q.regs[ADDR_CUR_MON[3:0]][CM_CAL_OUT_BIT];
    end

    if (!rstn_i) begin
      sy_d = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
        sy_d.regs[i] = REG_RESET;
      end
      sy_d.test = REG_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    sy_q <= sy_d;
  end

  assign short_trip_o                 = sy_q.short_trip;
  assign cell_tap_sel_o               = sy_q.cell_tap;
  assign cell_voltage_output_en_o     = sy_q.cell_en;
  assign amp_gain_select_o            = sy_q.gain;
  assign sense_positive_in_gnd_o      = sy_q.p_gnd;
  assign sense_negative_in_gnd_o      = sy_q.n_gnd;
  assign sense_positive_in_ref_o      = sy_q.p_ref;
  assign ref_level_20mv_o             = sy_q.ref20;
  assign current_monitor_output_ref_o = sy_q.out_ref;
  assign current_monitor_output_en_o  = sy_q.out_en;
  assign switch_driver_ctrl_o         = sy_q.regs[ADDR_SWITCH_DRV[3:0]];
  assign charger_detect_ctrl_o        = sy_q.regs[ADDR_CHG_DET[3:0]];
  assign load_short_detect_ctrl_o     = sy_q.regs[ADDR_LOAD_SHORT[3:0]];
  assign power_mode_ctrl_o            = sy_q.regs[ADDR_POWER_MODE[3:0]];
  assign internal_state_o             = sy_q.regs[ADDR_INT_STATE[3:0]];
  assign balance_upper_cells_o        = sy_q.regs[ADDR_BAL_UPPER[3:0]];
  assign balance_lower_cells_o        = sy_q.regs[ADDR_BAL_LOWER[3:0]];
  assign short_threshold_select_o     = sy_q.regs[ADDR_SHORT_THR[3:0]];

endmodule : mcrb_top

// [verification/mcrb_host_model.sv]
// Serial master model: command byte then data byte, MSB first, per frame.
// Assumes the device samples on rising and shifts on falling link clock.
`timescale 1ns/1ps
module mcrb_host_model (
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  // A chip-select pulse at start clears the link-side frame and read logic
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b0;
    sdi_o  = 1'b1;
    #1 cs_n_o = 1'b1;
  end
  task automatic xfer(input logic [15:0] f, input int nb, input realtime hp, output logic [7:0] rd);
    rd     = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 0; i < nb; i++) begin
      sdi_o = f[15-i];
      #(hp) sck_o = 1'b1;
      if (i >= 8) rd = {rd[6:0], sdo_i};
      #(hp) sck_o = 1'b0;
    end
    #(hp) cs_n_o = 1'b1;
    // Released line shows the inverse, never the last bit
    sdi_o = ~sdi_o;
    #(hp);
  endtask : xfer
endmodule : mcrb_host_model

// [verification/mcrb_assertions.sv]
// Checker on the top ports of the register bank.
// Assumes the system clock domain and its synchronous reset.
`timescale 1ns/1ps
module mcrb_chk (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        cs_n_i,
  input wire logic        serial_out_o,
  input wire logic        serial_out_oe_o,
  input wire logic        short_detect_i,
  input wire logic        short_trip_o,
  input wire logic [15:0] cell_tap_sel_o,
  input wire logic        cell_voltage_output_en_o,
  input wire logic        amp_gain_select_o,
  input wire logic        sense_positive_in_gnd_o,
  input wire logic        sense_negative_in_gnd_o,
  input wire logic        sense_positive_in_ref_o,
  input wire logic        ref_level_20mv_o,
  input wire logic        current_monitor_output_ref_o,
  input wire logic [7:0]  balance_upper_cells_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_cell_off_zero: assert property (!cell_voltage_output_en_o |-> cell_tap_sel_o == 16'h0000)
    else $error("cell tap active while disabled");
  a_cell_one_tap: assert property (cell_voltage_output_en_o |-> $onehot(cell_tap_sel_o))
    else $error("cell tap not one-hot");
  a_zero_wins: assert property (sense_positive_in_gnd_o |->
    sense_negative_in_gnd_o && !sense_positive_in_ref_o && !current_monitor_output_ref_o)
    else $error("zero correction not exclusive");
  a_cal_neg_gnd: assert property (sense_positive_in_ref_o |-> sense_negative_in_gnd_o)
    else $error("negative input not grounded in cal");
  a_ref_level: assert property (sense_positive_in_ref_o |-> ref_level_20mv_o == amp_gain_select_o)
    else $error("reference level mismatch");
  a_out_ref_cal: assert property (current_monitor_output_ref_o |-> sense_positive_in_ref_o)
    else $error("reference output without cal input");
  a_short_high: assert property (short_detect_i [*6] |-> short_trip_o)
    else $error("short trip missed");
  a_short_low: assert property (!short_detect_i [*6] |-> !short_trip_o)
    else $error("short trip stuck");
  a_idle_quiet: assert property (cs_n_i |-> !serial_out_oe_o && !serial_out_o)
    else $error("serial out driven outside frame");
  a_regs_still: assert property (cs_n_i [*8] |=> $stable(balance_upper_cells_o))
    else $error("register changed without access");
  c_cell_on: cover property (cell_voltage_output_en_o && cell_tap_sel_o[15]);
  c_ref_out: cover property (current_monitor_output_ref_o && ref_level_20mv_o);
  c_short: cover property (short_trip_o);
endmodule : mcrb_chk
bind mcrb_top mcrb_chk u_chk (.*);

// [verification/mcrb_top_test.sv]
// Self-checking bench: serial reads and writes against expected values.
// Assumes the host model as the only serial master.
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module mcrb_top_test;
  import mcrb_pkg::*;
  logic        clk_i = 1'b0, rstn_i = 1'b1, short_detect_i = 1'b0;
  logic        sck_i, cs_n_i, serial_in_i, serial_out_o, serial_out_oe_o, short_trip_o;
  logic        cell_voltage_output_en_o, amp_gain_select_o, sense_positive_in_gnd_o, sense_negative_in_gnd_o;
  logic        sense_positive_in_ref_o, ref_level_20mv_o, current_monitor_output_ref_o, current_monitor_output_en_o;
  logic [15:0] cell_tap_sel_o;
  logic [7:0]  switch_driver_ctrl_o, charger_detect_ctrl_o, load_short_detect_ctrl_o, power_mode_ctrl_o;
  logic [7:0]  internal_state_o, balance_upper_cells_o, balance_lower_cells_o, short_threshold_select_o, r;
  logic        z, ci;
  int          bad_count = 0, n_checks = 0, cyc = 0;
  realtime     hp = 7.5;
  wire  [5:0]  cur_w = {amp_gain_select_o, sense_positive_in_gnd_o, sense_negative_in_gnd_o,
                        sense_positive_in_ref_o, current_monitor_output_ref_o, current_monitor_output_en_o};
  mcrb_top dut (.*);
  mcrb_host_model h (.sck_o(sck_i), .cs_n_o(cs_n_i), .sdi_o(serial_in_i), .sdo_i(serial_out_o));
  always #4 clk_i = ~clk_i;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    @(negedge clk_i);
    h.xfer({DIR_WRITE, a, d}, 16, hp, q);
    repeat (8) @(negedge clk_i);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    @(negedge clk_i);
    h.xfer({DIR_READ, a, 8'h00}, 16, hp, q);
    `CHK("read", e, q)
    `CHK("oe", 1'b0, serial_out_oe_o)
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    // Falling edge clears the link-side write holder
    #1 rstn_i = 1'b0;
    repeat (8) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < 12; i++) rd(i < 11 ? 7'(i) : 7'h7F, REG_RESET);
    for (int i = 0; i < 11; i++) wr(7'(i), 8'hA5 ^ 8'(i));
    for (int i = 0; i < 11; i++) rd(7'(i), (8'hA5 ^ 8'(i)) & ((i == 1 || i == 2) ? 8'h1F : 8'hFF));
    `CHK("regs", 64'hA6A1_A0A3_A2AD_ACAF, {switch_driver_ctrl_o, charger_detect_ctrl_o, load_short_detect_ctrl_o, power_mode_ctrl_o, internal_state_o, balance_upper_cells_o, balance_lower_cells_o, short_threshold_select_o})
    // Unmapped addresses share one store; scratch must not move
    wr(7'h40, 8'h3C);
    rd(7'h7E, 8'h3C);
    rd(7'h00, 8'hA5);
    h.xfer({DIR_WRITE, 7'h00, 8'h00}, 15, hp, r);
    rd(7'h00, 8'hA5);
    for (int n = 0; n < 16; n++) begin
      wr(7'h01, 8'h10 | 8'(n));
      `CHK("tap", 16'h0001 << n, cell_tap_sel_o)
      `CHK("en", 1'b1, cell_voltage_output_en_o)
    end
    wr(7'h01, 8'h0F);
    `CHK("tap", 16'h0000, cell_tap_sel_o)
    `CHK("en", 1'b0, cell_voltage_output_en_o)
    // Every code of the current control, output enable among them
    for (int v = 0; v < 32; v++) begin
      wr(7'h02, 8'(v));
      z  = v[1];
      ci = v[2] & ~z;
      `CHK("cur", {v[0], z, z | ci, ci, ci & v[3], v[4]}, cur_w)
      if (ci) `CHK("ref", v[0], ref_level_20mv_o)
    end
    short_detect_i = 1'b1;
    repeat (6) @(negedge clk_i);
    `CHK("short", 1'b1, short_trip_o)
    wr(7'h02, 8'h00);
    `CHK("short", 1'b1, short_trip_o)
    short_detect_i = 1'b0;
    repeat (6) @(negedge clk_i);
    `CHK("short", 1'b0, short_trip_o)
    print_verdict();
  end
endmodule : mcrb_top_test
